// file: tap_prog_defines.vh
// constants for the test-port programming entry block
// Overview of operation
// - test port usable only with fuse programmed and disable bit clear
// - disable bit set and external reset low: bit clears after two core clocks
// - every shift register shifts least significant bit first
// - four-bit instruction register selects the data register between TDI and TDO
// - Run-Test/Idle yields internal programming clock pulses and serves as idle; code pulses only in programming mode under opcode 0x5
// - opcode 0xc selects one-bit core reset register; TAP itself not reset
// - core held in reset while reset register holds one, unlatched output
// - under core reset instruction only Shift-DR is active
// - opcode 0x4 selects sixteen-bit unlock register shifted in Shift-DR
// - on Update-DR unlock value compared; programming mode only on match
// - opcode 0x5 selects fifteen-bit programming command register
// - reset register one acts as external reset low; time-out after release
// - unlock register clears on power-on; signature 1010_0011_0111_0000
`ifndef TAP_PROG_DEFINES_VH
`define TAP_PROG_DEFINES_VH
`define IR_W            4
`define IR_CAPTURE      4'h1
`define IR_RESET_VAL    4'hf
`define OP_CORE_RESET   4'hc
`define OP_UNLOCK       4'h4
`define OP_COMMAND      4'h5
`define UNLOCK_W        16
`define UNLOCK_SIG      16'ha370
`define CMD_W           15
`define DIS_CLR_CYCLES  2'h2
`define TIMEOUT_W       16
`define ST_RESET        4'h0
`define ST_IDLE         4'h1
`define ST_SEL_DR       4'h2
`define ST_CAP_DR       4'h3
`define ST_SHIFT_DR     4'h4
`define ST_EXIT1_DR     4'h5
`define ST_PAUSE_DR     4'h6
`define ST_EXIT2_DR     4'h7
`define ST_UPD_DR       4'h8
`define ST_SEL_IR       4'h9
`define ST_CAP_IR       4'ha
`define ST_SHIFT_IR     4'hb
`define ST_EXIT1_IR     4'hc
`define ST_PAUSE_IR     4'hd
`define ST_EXIT2_IR     4'he
`define ST_UPD_IR       4'hf
`endif

// file: tap_fsm.v
// sixteen-state test-port controller, advanced by tck rising edge strobe
`timescale 1ns/10ps
`include "tap_prog_defines.vh"
module tap_fsm (
  // clock and reset
  input  wire       core_clk,
  input  wire       sys_rst,
  // strobes and pins, already synchronised
  input  wire       tck_rise,
  input  wire       tms_s,
  input  wire       port_en,
  // state
  output reg  [3:0] tap_state_ff
);
  reg [3:0] nxt_tap_state;

  always @*
  begin
    nxt_tap_state = tap_state_ff;
    case (tap_state_ff)
      `ST_RESET:    nxt_tap_state = tms_s ? `ST_RESET    : `ST_IDLE;
      `ST_IDLE:     nxt_tap_state = tms_s ? `ST_SEL_DR   : `ST_IDLE;
      `ST_SEL_DR:   nxt_tap_state = tms_s ? `ST_SEL_IR   : `ST_CAP_DR;
      `ST_CAP_DR:   nxt_tap_state = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_SHIFT_DR: nxt_tap_state = tms_s ? `ST_EXIT1_DR : `ST_SHIFT_DR;
      `ST_EXIT1_DR: nxt_tap_state = tms_s ? `ST_UPD_DR   : `ST_PAUSE_DR;
      `ST_PAUSE_DR: nxt_tap_state = tms_s ? `ST_EXIT2_DR : `ST_PAUSE_DR;
      `ST_EXIT2_DR: nxt_tap_state = tms_s ? `ST_UPD_DR   : `ST_SHIFT_DR;
      `ST_UPD_DR:   nxt_tap_state = tms_s ? `ST_SEL_DR   : `ST_IDLE;
      `ST_SEL_IR:   nxt_tap_state = tms_s ? `ST_RESET    : `ST_CAP_IR;
      `ST_CAP_IR:   nxt_tap_state = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_SHIFT_IR: nxt_tap_state = tms_s ? `ST_EXIT1_IR : `ST_SHIFT_IR;
      `ST_EXIT1_IR: nxt_tap_state = tms_s ? `ST_UPD_IR   : `ST_PAUSE_IR;
      `ST_PAUSE_IR: nxt_tap_state = tms_s ? `ST_EXIT2_IR : `ST_PAUSE_IR;
      `ST_EXIT2_IR: nxt_tap_state = tms_s ? `ST_UPD_IR   : `ST_SHIFT_IR;
      `ST_UPD_IR:   nxt_tap_state = tms_s ? `ST_SEL_DR   : `ST_IDLE;
      default:      nxt_tap_state = `ST_RESET;
    endcase
  end

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      tap_state_ff <= `ST_RESET;
    else if (!port_en)
      tap_state_ff <= `ST_RESET;
    else if (tck_rise)
      tap_state_ff <= nxt_tap_state;
  end
endmodule // tap_fsm

// file: jtag_programming_entry.v
// test-port programming entry: tap, instruction and programming data registers
`timescale 1ns/10ps
`include "tap_prog_defines.vh"
module jtag_programming_entry (
  // clock and reset
  input  wire                   core_clk,
  input  wire                   sys_rst,
  // test-port pins
  input  wire                   tck,
  input  wire                   tms,
  input  wire                   tdi,
  output reg                    tdo_ff,
  output reg                    tdo_oe_ff,
  // device configuration and core reset
  input  wire                   test_port_fuse,
  input  wire                   ext_reset_n,
  input  wire                   disable_set,
  output reg                    test_port_disable_bit_ff,
  output reg                    core_reset_ff,
  // programming side
  output reg                    prog_mode_ff,
  output reg  [`CMD_W-1:0]      prog_cmd_ff,
  output reg                    prog_cmd_valid_ff,
  output reg                    prog_clk_pulse_ff,
  input  wire [`CMD_W-1:0]      prog_result
);
  parameter [`TIMEOUT_W-1:0] RESET_TIMEOUT_CYCLES = 16'h0040;

  // pin synchronisers
  reg [1:0] tck_sync_ff;
  reg [1:0] tms_sync_ff;
  reg [1:0] tdi_sync_ff;
  reg [1:0] rstn_sync_ff;
  reg [1:0] fuse_sync_ff;
  reg       tck_prev_ff;
  reg [1:0] dis_cnt_ff;
  reg [`IR_W-1:0]     ir_shift_ff;
  reg [`IR_W-1:0]     ir_ff;
  reg                 rst_reg_ff;
  reg [`UNLOCK_W-1:0] unlock_ff;
  reg [`CMD_W-1:0]    cmd_shift_ff;
  reg                 bypass_ff;
  reg [`TIMEOUT_W-1:0] timeout_ff;
  wire [3:0] tap_state;
  wire tck_s     = tck_sync_ff[1];
  wire tck_rise  = tck_s & ~tck_prev_ff;
  wire tck_fall  = ~tck_s & tck_prev_ff;
  wire tms_s     = tms_sync_ff[1];
  wire tdi_s     = tdi_sync_ff[1];
  wire port_en   = fuse_sync_ff[1] & ~test_port_disable_bit_ff;

  function sel;
    input [`IR_W-1:0] ir;
    input [`IR_W-1:0] op;
    begin
      sel = (ir == op);
    end
  endfunction

  wire in_state_rise = port_en & tck_rise;
  wire shift_dr = in_state_rise & (tap_state == `ST_SHIFT_DR);
  wire cap_dr   = in_state_rise & (tap_state == `ST_CAP_DR);
  wire upd_dr   = in_state_rise & (tap_state == `ST_UPD_DR);

  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tck_sync_ff  <= 2'h0;
      tms_sync_ff  <= 2'h3;
      tdi_sync_ff  <= 2'h0;
      rstn_sync_ff <= 2'h3;
      fuse_sync_ff <= 2'h0;
      tck_prev_ff  <= 1'h0;
    end
    else
    begin
      tck_sync_ff  <= {tck_sync_ff[0], tck};
      tms_sync_ff  <= {tms_sync_ff[0], tms};
      tdi_sync_ff  <= {tdi_sync_ff[0], tdi};
      rstn_sync_ff <= {rstn_sync_ff[0], ext_reset_n};
      fuse_sync_ff <= {fuse_sync_ff[0], test_port_fuse};
      tck_prev_ff  <= tck_s;
    end
  end

  tap_fsm u_tap_fsm (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .tck_rise     (tck_rise),
    .tms_s        (tms_s),
    .port_en      (port_en),
    .tap_state_ff (tap_state)
  );

  // disable bit, cleared by a held external reset
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      test_port_disable_bit_ff <= 1'h0;
      dis_cnt_ff               <= 2'h0;
    end
    else if (!rstn_sync_ff[1] && test_port_disable_bit_ff)
    begin
      dis_cnt_ff <= dis_cnt_ff + 2'h1;
      if (dis_cnt_ff + 2'h1 == `DIS_CLR_CYCLES)
        test_port_disable_bit_ff <= 1'h0;
    end
    else
    begin
      dis_cnt_ff <= 2'h0;
      if (disable_set && rstn_sync_ff[1])
        test_port_disable_bit_ff <= 1'h1;
    end
  end

  // instruction register
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ir_shift_ff <= `IR_RESET_VAL;
      ir_ff       <= `IR_RESET_VAL;
    end
    else if (!port_en || tap_state == `ST_RESET)
    begin
      ir_shift_ff <= `IR_RESET_VAL;
      ir_ff       <= `IR_RESET_VAL;
    end
    else if (tck_rise)
    begin
      case (tap_state)
        `ST_CAP_IR:   ir_shift_ff <= `IR_CAPTURE;
        `ST_SHIFT_IR: ir_shift_ff <= {tdi_s, ir_shift_ff[`IR_W-1:1]};
        `ST_UPD_IR:   ir_ff <= ir_shift_ff;
        default:      ir_shift_ff <= ir_shift_ff;
      endcase
    end
  end

  // data registers selected by the instruction
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rst_reg_ff        <= 1'h0;
      unlock_ff         <= {`UNLOCK_W{1'b0}};
      cmd_shift_ff      <= {`CMD_W{1'b0}};
      bypass_ff         <= 1'h0;
      prog_mode_ff      <= 1'h0;
      prog_cmd_ff       <= {`CMD_W{1'b0}};
      prog_cmd_valid_ff <= 1'h0;
    end
    else
    begin
      prog_cmd_valid_ff <= 1'h0;
      if (shift_dr && sel(ir_ff, `OP_CORE_RESET))
        rst_reg_ff <= tdi_s;
      if (shift_dr && sel(ir_ff, `OP_UNLOCK))
        unlock_ff <= {tdi_s, unlock_ff[`UNLOCK_W-1:1]};
      if (upd_dr && sel(ir_ff, `OP_UNLOCK))
        prog_mode_ff <= (unlock_ff == `UNLOCK_SIG);
      if (cap_dr && sel(ir_ff, `OP_COMMAND))
        cmd_shift_ff <= prog_result;
      if (shift_dr && sel(ir_ff, `OP_COMMAND))
        cmd_shift_ff <= {tdi_s, cmd_shift_ff[`CMD_W-1:1]};
      if (upd_dr && sel(ir_ff, `OP_COMMAND))
      begin
        prog_cmd_ff       <= cmd_shift_ff;
        prog_cmd_valid_ff <= prog_mode_ff;
      end
      if (shift_dr)
        bypass_ff <= tdi_s;
    end
  end

  // core reset: immediate while set, then time-out
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      core_reset_ff <= 1'h1;
      timeout_ff    <= RESET_TIMEOUT_CYCLES;
    end
    else if (rst_reg_ff || !rstn_sync_ff[1])
    begin
      core_reset_ff <= 1'h1;
      timeout_ff    <= RESET_TIMEOUT_CYCLES;
    end
    else if (timeout_ff != {`TIMEOUT_W{1'b0}})
    begin
      core_reset_ff <= 1'h1;
      timeout_ff    <= timeout_ff - {{(`TIMEOUT_W-1){1'b0}}, 1'b1};
    end
    else
      core_reset_ff <= 1'h0;
  end

  // run-test/idle clock pulses for programming
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      prog_clk_pulse_ff <= 1'h0;
    else
      prog_clk_pulse_ff <= in_state_rise && tap_state == `ST_IDLE
                           && prog_mode_ff && sel(ir_ff, `OP_COMMAND);
  end

  // tdo on tck falling edge, lsb of selected register
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tdo_ff    <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end
    else if (!port_en)
    begin
      tdo_ff    <= 1'h0;
      tdo_oe_ff <= 1'h0;
    end
    else if (tck_fall)
    begin
      tdo_oe_ff <= (tap_state == `ST_SHIFT_DR) || (tap_state == `ST_SHIFT_IR);
      if (tap_state == `ST_SHIFT_IR)
        tdo_ff <= ir_shift_ff[0];
      else if (sel(ir_ff, `OP_CORE_RESET))
        tdo_ff <= rst_reg_ff;
      else if (sel(ir_ff, `OP_UNLOCK))
        tdo_ff <= unlock_ff[0];
      else if (sel(ir_ff, `OP_COMMAND))
        tdo_ff <= cmd_shift_ff[0];
      else
        tdo_ff <= bypass_ff;
    end
  end
endmodule // jtag_programming_entry

// file: jtag_programming_entry_assertions.sv
// port checks for the test-port programming entry block
`timescale 1ns/10ps
module jtag_programming_entry_assertions #(
  parameter [15:0] RESET_TIMEOUT_CYCLES = 16'h0040
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // pins and status
  input wire logic tck,
  input wire logic tdo_ff,
  input wire logic tdo_oe_ff,
  input wire logic test_port_fuse,
  input wire logic ext_reset_n,
  input wire logic test_port_disable_bit_ff,
  input wire logic core_reset_ff,
  input wire logic prog_mode_ff,
  input wire logic prog_cmd_valid_ff,
  input wire logic prog_clk_pulse_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_fuse_off;
    !test_port_fuse [*5];
  endsequence
  sequence s_disabled;
    test_port_disable_bit_ff [*3];
  endsequence
  sequence s_pin_low_disabled;
    (test_port_disable_bit_ff && !ext_reset_n) [*7];
  endsequence
  property p_fuse_blocks;
    s_fuse_off |-> !tdo_oe_ff;
  endproperty
  property p_disable_blocks;
    s_disabled |-> !tdo_oe_ff;
  endproperty
  property p_disable_clears;
    s_pin_low_disabled |-> 1'b0;
  endproperty
  property p_pin_reset;
    !ext_reset_n [*4] |-> core_reset_ff;
  endproperty
  property p_timeout;
    $fell(core_reset_ff) |-> $past(core_reset_ff, RESET_TIMEOUT_CYCLES);
  endproperty
  property p_cmd_in_mode;
    prog_cmd_valid_ff |-> prog_mode_ff ##1 !prog_cmd_valid_ff;
  endproperty
  property p_pulse_in_mode;
    prog_clk_pulse_ff |-> prog_mode_ff ##1 !prog_clk_pulse_ff;
  endproperty
  property p_tdo_on_fall;
    $changed(tdo_ff) |-> !tck && !$past(tck, 2);
  endproperty
  a_fuse_blocks: assert property (p_fuse_blocks) else $error("tdo on, fuse off");
  a_disable_blocks: assert property (p_disable_blocks) else $error("tdo on, disabled");
  a_disable_clears: assert property (p_disable_clears) else $error("bit not cleared");
  a_pin_reset: assert property (p_pin_reset) else $error("no core reset");
  a_timeout: assert property (p_timeout) else $error("time-out short");
  a_cmd_in_mode: assert property (p_cmd_in_mode) else $error("bad cmd strobe");
  a_pulse_in_mode: assert property (p_pulse_in_mode) else $error("bad clk pulse");
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo off fall");
endmodule // jtag_programming_entry_assertions
bind jtag_programming_entry jtag_programming_entry_assertions #(
  .RESET_TIMEOUT_CYCLES(RESET_TIMEOUT_CYCLES)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tdo_ff(tdo_ff),
  .tdo_oe_ff(tdo_oe_ff), .test_port_fuse(test_port_fuse), .ext_reset_n(ext_reset_n),
  .test_port_disable_bit_ff(test_port_disable_bit_ff), .core_reset_ff(core_reset_ff),
  .prog_mode_ff(prog_mode_ff), .prog_cmd_valid_ff(prog_cmd_valid_ff),
  .prog_clk_pulse_ff(prog_clk_pulse_ff));

// file: jtag_programmer.sv
// behavioural test-port programmer
`timescale 1ns/10ps
module jtag_programmer (
  // four link pins only
  output logic tck,
  output logic tms,
  output logic tdi,
  input  wire  tdo
);
  logic o;
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    #62.5;
    q = tdo;
    tck <= 1'b1;
    #62.5;
    tck <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) step(1'b0, tdi, o);
  endtask
  task automatic tap_reset();
    repeat (5) step(1'b1, tdi, o);
    idle(1);
  endtask
  task automatic scan(input logic ir, input int n, input logic [15:0] din,
                      output logic [15:0] dout);
    dout = 16'h0000;
    step(1'b1, tdi, o);
    if (ir)
      step(1'b1, tdi, o);
    step(1'b0, tdi, o);
    step(1'b0, tdi, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, ~tdi, o);
    idle(1);
  endtask
endmodule // jtag_programmer

// file: test_jtag_programming_entry.sv
// self-checking bench for the test-port programming entry block
`timescale 1ns/10ps
`include "tap_prog_defines.vh"
module test_jtag_programming_entry;
  logic        core_clk, sys_rst, test_port_fuse, ext_reset_n, disable_set;
  logic [14:0] prog_result;
  logic [15:0] d;
  wire         tck, tms, tdi, tdo_ff, tdo_oe_ff, dis_bit, core_rst, mode, cmd_v, pulse;
  wire  [14:0] cmd;
  int          errors, total_checks, cycles, pulses, p0, strobes;
  jtag_programming_entry #(.RESET_TIMEOUT_CYCLES(16'h0040)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_ff(tdo_ff), .tdo_oe_ff(tdo_oe_ff), .test_port_fuse(test_port_fuse),
    .ext_reset_n(ext_reset_n), .disable_set(disable_set),
    .test_port_disable_bit_ff(dis_bit), .core_reset_ff(core_rst), .prog_mode_ff(mode),
    .prog_cmd_ff(cmd), .prog_cmd_valid_ff(cmd_v), .prog_clk_pulse_ff(pulse),
    .prog_result(prog_result));
  jtag_programmer i_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_ff));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic results();
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (pulse === 1'b1)
      pulses <= pulses + 1;
    if (cmd_v === 1'b1)
      strobes <= strobes + 1;
    if (cycles == 30000)
    begin
      errors = errors + 1;
      results();
    end
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic t_refused();
    @(posedge core_clk);
    test_port_fuse <= 1'b0;
    i_prog.tap_reset();
    i_prog.scan(1'b1, 4, `OP_CORE_RESET, d);
    i_prog.scan(1'b0, 1, 16'h0001, d);
    chk("core_reset_fuse_off", 16'h0, core_rst);
    chk("oe_fuse_off", 16'h0, tdo_oe_ff);
    @(posedge core_clk);
    test_port_fuse <= 1'b1;
  endtask
  task automatic t_core_reset();
    i_prog.tap_reset();
    i_prog.scan(1'b1, 4, `OP_CORE_RESET, d);
    chk("ir_capture", `IR_CAPTURE, d);
    i_prog.scan(1'b0, 1, 16'h0001, d);
    chk("core_reset_set", 16'h1, core_rst);
    i_prog.scan(1'b0, 1, 16'h0000, d);
    chk("reset_bit_out", 16'h1, d);
    chk("timeout_hold", 16'h1, core_rst);
    repeat (70) @(posedge core_clk);
    chk("timeout_end", 16'h0, core_rst);
  endtask
  task automatic t_unlock(logic [15:0] sig, logic [15:0] exp);
    i_prog.scan(1'b1, 4, `OP_UNLOCK, d);
    i_prog.scan(1'b0, 16, sig, d);
    chk("prog_mode", exp, mode);
  endtask
  task automatic t_command();
    @(posedge core_clk);
    prog_result <= 15'h5a3c;
    i_prog.scan(1'b1, 4, `OP_COMMAND, d);
    i_prog.scan(1'b0, 15, 16'h1234, d);
    chk("cmd_result", 16'h5a3c, d);
    chk("cmd_value", 16'h1234, cmd);
    chk("cmd_strobe", 16'h1, 16'(strobes));
    p0 = pulses;
    i_prog.idle(3);
    chk("clk_pulses", 16'h3, 16'(pulses - p0));
    chk("oe_idle", 16'h0, tdo_oe_ff);
  endtask
  task automatic t_disable();
    @(posedge core_clk);
    disable_set <= 1'b1;
    @(posedge core_clk);
    disable_set <= 1'b0;
    i_prog.scan(1'b1, 4, `OP_CORE_RESET, d);
    i_prog.scan(1'b0, 1, 16'h0001, d);
    chk("dis_set", 16'h1, dis_bit);
    chk("core_reset_disabled", 16'h0, core_rst);
    @(posedge core_clk);
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("dis_cleared", 16'h0, dis_bit);
    chk("pin_reset", 16'h1, core_rst);
    ext_reset_n <= 1'b1;
    repeat (75) @(posedge core_clk);
    chk("pin_release", 16'h0, core_rst);
  endtask
  initial
  begin
    errors = 0;
    total_checks = 0;
    cycles = 0;
    pulses = 0;
    strobes = 0;
    sys_rst = 1'b1;
    test_port_fuse = 1'b1;
    ext_reset_n = 1'b1;
    disable_set = 1'b0;
    prog_result = 15'h0000;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_refused();
    t_core_reset();
    t_unlock(`UNLOCK_SIG ^ 16'h8000, 16'h0);
    t_unlock(`UNLOCK_SIG, 16'h1);
    t_command();
    t_unlock(16'h0000, 16'h0);
    t_disable();
    i_prog.tap_reset();
    results();
  end
endmodule // test_jtag_programming_entry
